// >>> omw_pkg.sv
// package: constants, types and rule summary for the operating mode and wake-up controller
// assumes one 250 MHz clock, synchronous active-low reset, apb register access
// Summary of operation
// RULE1: clear high select, divider 000/001 selects slow
// RULE2: slow switch completes once low-speed ready
// RULE3: high select or divider 010-111 returns high-speed
// RULE4: software polls high-speed ready after switching
// RULE5: halt, idle off, watchdog/detector off: deep stop
// RULE6: deep stop clears and stops watchdog
// RULE7: halt, idle off, watchdog/detector on: light stop
// RULE8: light stop clears watchdog, sub-clock keeps counting
// RULE9: idle on, clock keep off: idle stop
// RULE10: idle stop: sub-clock watchdog runs, system watchdog stops
// RULE11: idle on, clock keep on: idle run
// RULE12: any halt sets power-down, clears timeout flag
// RULE13: wake on reset, port fall, interrupt, overflow
// RULE14: reset wake full reset; overflow sets timeout
// RULE15: power-down cleared by power-up or watchdog clear
// RULE16: per-pin port wake enables, falling edge wakes
// RULE17: disabled or stack-full interrupt resumes, stays pending
// RULE18: interrupt pending before halt cannot wake
// RULE19: crystals share start-up timer, high first
// RULE20: deep stop wake runs after high ready
// RULE21: light stop fast wake may run sub-clock
// RULE22: system-clocked peripherals follow clock source switch
// RULE23: high select picks undivided clock; low stops high
// RULE24: high ready low in stop, 1024 or 16 cycles
// RULE25: fast wake runs sub-clock for 1024 crystal cycles
// RULE26: halt mode decided combinationally in halt cycle
package omw_pkg;
	localparam logic [7:0] ADDR_SYS_MODE = 8'h00;
	localparam logic [7:0] ADDR_WDG_CTRL = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_WAKE_EN = 8'h0c;
	localparam logic [7:0] ADDR_OSC_CFG = 8'h10;
	localparam logic [7:0] SYS_MODE_RST = 8'h01;
	localparam logic [7:0] WDG_CTRL_RST = 8'h7a;
	localparam logic [3:0] WDG_OFF_CODE = 4'ha;
	localparam logic [2:0] DIV_SLOW_MAX = 3'h1;
	localparam int HX_START_CYC = 1024;
	localparam int RC_START_CYC = 16;
	localparam int LX_START_CYC = 1024;
	localparam int TMR_W = 11;
	// system mode register layout
	typedef struct packed {
		logic [2:0] clock_divider_select;
		logic fast_wake_enable;
		logic low_speed_ready_flag;
		logic high_speed_ready_flag;
		logic idle_enable;
		logic high_clock_select;
	} omw_smode_t;
	typedef enum logic [4:0] {
		OMW_RUN = 5'h01,
		OMW_DEEP = 5'h02,
		OMW_LIGHT = 5'h04,
		OMW_IDLE_STOP_MODE = 5'h08,
		OMW_IDLE_RUN_MODE = 5'h10
	} omw_state_t;
	typedef enum logic [2:0] {
		OMW_T_IDLE = 3'h1,
		OMW_T_HIGH = 3'h2,
		OMW_T_LOW = 3'h4
	} omw_tmr_t;
	// clock gate set for the chip
	typedef struct packed {
		logic sys_clk_on;
		logic tbase_clk_on;
		logic sub_clk_on;
		logic sys_from_low;
		logic high_osc_on;
	} omw_clk_t;
endpackage

// >>> omw_sync.sv
// three-flop pin synchroniser with agreement filter
// assumes pins are asynchronous to the clock
`timescale 1ns/1ps
module omw_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_reg <= '1;
			s2_reg <= '1;
			s3_reg <= '1;
			q <= '1;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			// a bit changes only when the two later stages agree
			q <= (s2_reg & s3_reg) | (q & (s2_reg ^ s3_reg));
		end
	end
endmodule

// >>> omw_startup.sv
// shared oscillator start-up timer, high-speed period first then low-speed
// assumes start requests are held as levels until the ready flag rises
`timescale 1ns/1ps
module omw_startup #(
	parameter int HX_CYC = omw_pkg::HX_START_CYC,
	parameter int RC_CYC = omw_pkg::RC_START_CYC,
	parameter int LX_CYC = omw_pkg::LX_START_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic high_stop,
	input wire logic low_stop,
	input wire logic high_is_crystal,
	output logic high_ready,
	output logic low_ready
);
	omw_pkg::omw_tmr_t st_reg;
	logic [omw_pkg::TMR_W-1:0] cnt_reg;
	logic [omw_pkg::TMR_W-1:0] hi_len;
	// rc sources settle in far fewer cycles than the crystal
	assign hi_len = high_is_crystal ? omw_pkg::TMR_W'(HX_CYC - 1) : omw_pkg::TMR_W'(RC_CYC - 1);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg <= omw_pkg::OMW_T_IDLE;
			cnt_reg <= '0;
			high_ready <= 1'b0;
			low_ready <= 1'b0;
		end else begin
			if (high_stop)
				high_ready <= 1'b0; // see RULE24
			if (low_stop)
				low_ready <= 1'b0;
			case (st_reg)
				omw_pkg::OMW_T_IDLE: begin
					cnt_reg <= '0;
					if (!high_stop && !high_ready)
						st_reg <= omw_pkg::OMW_T_HIGH;
					else if (!low_stop && !low_ready)
						st_reg <= omw_pkg::OMW_T_LOW; // see RULE19
				end
				omw_pkg::OMW_T_HIGH: begin
					cnt_reg <= cnt_reg + 1'b1;
					if (high_stop) begin
						st_reg <= omw_pkg::OMW_T_IDLE;
					end else if (cnt_reg == hi_len) begin
						high_ready <= 1'b1; // see RULE24
						st_reg <= omw_pkg::OMW_T_IDLE;
					end
				end
				omw_pkg::OMW_T_LOW: begin
					cnt_reg <= cnt_reg + 1'b1;
					if (low_stop) begin
						st_reg <= omw_pkg::OMW_T_IDLE;
					end else if (cnt_reg == omw_pkg::TMR_W'(LX_CYC - 1)) begin
						low_ready <= 1'b1; // see RULE19
						st_reg <= omw_pkg::OMW_T_IDLE;
					end
				end
				default: st_reg <= omw_pkg::OMW_T_IDLE;
			endcase
		end
	end
endmodule

// >>> omw_ctrl.sv
// top: operating mode and wake-up controller with apb registers
// assumes core drives halt and watchdog-clear pulses on REF_CLK; port pins asynchronous
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module omw_ctrl #(
	parameter int PORT_W = 8,
	parameter int HX_CYC = omw_pkg::HX_START_CYC,
	parameter int RC_CYC = omw_pkg::RC_START_CYC,
	parameter int LX_CYC = omw_pkg::LX_START_CYC
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RESET_N,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// core events
	input wire logic HALT_EXEC,
	input wire logic WDG_CLEAR,
	input wire logic WDG_OVERFLOW,
	input wire logic DETECTOR_ON,
	input wire logic EXT_RESET_WAKE,
	input wire logic [7:0] INT_REQ,
	input wire logic [7:0] INT_ENABLE,
	input wire logic STACK_FULL,
	// port a pins
	input wire logic [PORT_W-1:0] PORT_A_PIN,
	// clock, watchdog, wake and interrupt outputs
	output omw_pkg::omw_clk_t CLK_CTRL,
	output logic WDG_RESET,
	output logic WDG_RUN,
	output logic CORE_HALTED,
	output logic WAKE_RESUME,
	output logic WAKE_PC_SP_RESET,
	output logic WAKE_FULL_RESET,
	output logic INT_SERVICE,
	output logic [7:0] INT_PENDING
);
	omw_pkg::omw_state_t st_reg;
	omw_pkg::omw_state_t halt_mode;
	omw_pkg::omw_smode_t smode_reg;
	logic [7:0] wdg_ctrl_reg;
	logic [PORT_W-1:0] port_a_wake_enable_reg;
	logic wdg_from_sub_reg;
	logic hs_is_crystal_reg;
	logic power_down_flag_reg;
	logic timeout_flag_reg;
	logic [7:0] int_mask_reg;
	logic [7:0] int_pend_reg;
	logic [PORT_W-1:0] pin_q;
	logic [PORT_W-1:0] pin_last_reg;
	logic wdg_enabled;
	logic slow_req;
	logic slow_active_reg;
	logic fast_run_reg;
	logic high_stop;
	logic low_stop;
	logic high_ready;
	logic low_ready;
	logic halted;
	logic port_wake;
	logic [7:0] int_wake_vec;
	logic wake_any;
	logic wr_en;
	logic rd_en;
	logic idle_clock_keep;
	logic halt_take;
	logic addr_hit;

	assign wr_en = PSEL && PENABLE && PWRITE;
	assign rd_en = PSEL && !PENABLE && !PWRITE;
	assign idle_clock_keep = wdg_ctrl_reg[7];
	// a halt seen while already halted is ignored: a stopped core cannot issue one
	assign halt_take = HALT_EXEC && !halted;
	assign wdg_enabled = wdg_ctrl_reg[3:0] != omw_pkg::WDG_OFF_CODE;
	assign halted = st_reg != omw_pkg::OMW_RUN;
	// slow operation when high select is clear and divider names the low clock
	assign slow_req = !smode_reg.high_clock_select &&
		(smode_reg.clock_divider_select <= omw_pkg::DIV_SLOW_MAX); // see RULE1 see RULE3

	// halt mode chosen in the halt cycle itself
	always_comb begin
		if (smode_reg.idle_enable && idle_clock_keep)
			halt_mode = omw_pkg::OMW_IDLE_RUN_MODE; // see RULE11 see RULE26
		else if (smode_reg.idle_enable)
			halt_mode = omw_pkg::OMW_IDLE_STOP_MODE; // see RULE9
		else if (wdg_enabled || DETECTOR_ON)
			halt_mode = omw_pkg::OMW_LIGHT; // see RULE7
		else
			halt_mode = omw_pkg::OMW_DEEP; // see RULE5
	end

	// high oscillator stops in stop and idle-stop modes and in slow operation while the core is not halted
	assign high_stop = (st_reg == omw_pkg::OMW_DEEP) || (st_reg == omw_pkg::OMW_LIGHT) ||
		(st_reg == omw_pkg::OMW_IDLE_STOP_MODE) || (slow_active_reg && !halted); // see RULE23 see RULE24
	assign low_stop = st_reg == omw_pkg::OMW_DEEP;

	omw_startup #(
		.HX_CYC(HX_CYC),
		.RC_CYC(RC_CYC),
		.LX_CYC(LX_CYC)
	) u_startup (
		.clk(REF_CLK),
		.rst_n(RESET_N),
		.high_stop(high_stop),
		.low_stop(low_stop),
		.high_is_crystal(hs_is_crystal_reg),
		.high_ready(high_ready),
		.low_ready(low_ready)
	);

	omw_sync #(
		.W(PORT_W)
	) u_pin_sync (
		.clk(REF_CLK),
		.rst_n(RESET_N),
		.d(PORT_A_PIN),
		.q(pin_q)
	);

	// enables act on the filtered pins, so a glitch shorter than two clocks cannot wake
	assign port_wake = |(pin_last_reg & ~pin_q & port_a_wake_enable_reg); // see RULE16
	// only requests that rose after the halt may wake
	assign int_wake_vec = INT_REQ & ~int_mask_reg; // see RULE18
	assign wake_any = port_wake || (|int_wake_vec) || WDG_OVERFLOW || EXT_RESET_WAKE; // see RULE13

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N)
			pin_last_reg <= '1;
		else
			pin_last_reg <= pin_q;
	end

	// mode state machine
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			st_reg <= omw_pkg::OMW_RUN;
			int_mask_reg <= '0;
			fast_run_reg <= 1'b0;
		end else begin
			case (st_reg)
				omw_pkg::OMW_RUN: begin
					if (high_ready)
						fast_run_reg <= 1'b0; // see RULE25
					if (HALT_EXEC) begin
						st_reg <= halt_mode;
						int_mask_reg <= INT_REQ; // see RULE18
					end
				end
				omw_pkg::OMW_DEEP, omw_pkg::OMW_LIGHT, omw_pkg::OMW_IDLE_STOP_MODE,
				omw_pkg::OMW_IDLE_RUN_MODE: begin
					if (wake_any) begin
						st_reg <= omw_pkg::OMW_RUN;
						// fast wake only where the sub-clock survived the halt
						fast_run_reg <= smode_reg.fast_wake_enable && hs_is_crystal_reg &&
							(st_reg != omw_pkg::OMW_DEEP) && (st_reg != omw_pkg::OMW_IDLE_RUN_MODE); // see RULE21
					end
				end
				default: st_reg <= omw_pkg::OMW_RUN;
			endcase
		end
	end

	// clock source selection follows ready flags
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N)
			slow_active_reg <= 1'b0;
		else if (slow_req && low_ready)
			slow_active_reg <= 1'b1; // see RULE2
		else if (!slow_req)
			slow_active_reg <= 1'b0; // see RULE3
	end

	// clock gate outputs
	// the core stays halted while high is not ready and neither fast wake nor slow operation is active
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			CLK_CTRL <= '0;
			CORE_HALTED <= 1'b0;
		end else begin
			CLK_CTRL.sys_clk_on <= (st_reg == omw_pkg::OMW_RUN && (high_ready || fast_run_reg ||
				slow_active_reg)) || st_reg == omw_pkg::OMW_IDLE_RUN_MODE; // see RULE20
			CLK_CTRL.tbase_clk_on <= st_reg == omw_pkg::OMW_RUN || st_reg == omw_pkg::OMW_IDLE_STOP_MODE ||
				st_reg == omw_pkg::OMW_IDLE_RUN_MODE; // see RULE9
			CLK_CTRL.sub_clk_on <= st_reg != omw_pkg::OMW_DEEP; // see RULE5 see RULE7
			CLK_CTRL.sys_from_low <= slow_active_reg || (fast_run_reg && !high_ready); // see RULE22 see RULE25
			CLK_CTRL.high_osc_on <= !high_stop; // see RULE23
			CORE_HALTED <= halted || (!high_ready && !fast_run_reg && !slow_active_reg); // see RULE20
		end
	end

	// watchdog control
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			WDG_RESET <= 1'b0;
			WDG_RUN <= 1'b0;
		end else begin
			WDG_RESET <= halt_take || WDG_CLEAR; // see RULE6 see RULE8
			case (st_reg)
				omw_pkg::OMW_DEEP: WDG_RUN <= 1'b0; // see RULE6
				omw_pkg::OMW_LIGHT, omw_pkg::OMW_IDLE_STOP_MODE: WDG_RUN <= wdg_enabled && wdg_from_sub_reg; // see RULE8 see RULE10
				default: WDG_RUN <= wdg_enabled; // see RULE11
			endcase
		end
	end

	// status flags: halt and overflow set over software clear
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			power_down_flag_reg <= 1'b0;
			timeout_flag_reg <= 1'b0;
		end else begin
			if (halt_take)
				power_down_flag_reg <= 1'b1; // see RULE12 see RULE15
			else if (WDG_CLEAR)
				power_down_flag_reg <= 1'b0; // see RULE15
			if (WDG_OVERFLOW)
				timeout_flag_reg <= 1'b1; // see RULE14
			else if (halt_take || WDG_CLEAR)
				timeout_flag_reg <= 1'b0; // see RULE12
		end
	end

	// wake response pulses and interrupt pending
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			WAKE_RESUME <= 1'b0;
			WAKE_PC_SP_RESET <= 1'b0;
			WAKE_FULL_RESET <= 1'b0;
			INT_SERVICE <= 1'b0;
			int_pend_reg <= '0;
		end else begin
			WAKE_RESUME <= 1'b0;
			WAKE_PC_SP_RESET <= 1'b0;
			WAKE_FULL_RESET <= 1'b0;
			INT_SERVICE <= 1'b0;
			int_pend_reg <= int_pend_reg & INT_REQ;
			if (halted && wake_any) begin
				if (EXT_RESET_WAKE)
					WAKE_FULL_RESET <= 1'b1; // see RULE14
				else if (WDG_OVERFLOW)
					WAKE_PC_SP_RESET <= 1'b1; // see RULE14
				else if (|(int_wake_vec & INT_ENABLE) && !STACK_FULL)
					INT_SERVICE <= 1'b1; // see RULE17
				else begin
					WAKE_RESUME <= 1'b1; // see RULE16 see RULE17
					int_pend_reg <= int_pend_reg | int_wake_vec; // see RULE17
				end
			end
		end
	end

	// apb register writes
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			smode_reg <= omw_pkg::SYS_MODE_RST;
			wdg_ctrl_reg <= omw_pkg::WDG_CTRL_RST;
			port_a_wake_enable_reg <= '0;
			wdg_from_sub_reg <= 1'b1;
			hs_is_crystal_reg <= 1'b1;
		end else begin
			smode_reg.high_speed_ready_flag <= high_ready; // see RULE4
			smode_reg.low_speed_ready_flag <= low_ready;
			if (wr_en) begin
				if (PADDR == omw_pkg::ADDR_SYS_MODE) begin
					smode_reg.clock_divider_select <= PWDATA[7:5];
					smode_reg.fast_wake_enable <= PWDATA[4];
					smode_reg.idle_enable <= PWDATA[1];
					smode_reg.high_clock_select <= PWDATA[0];
				end else if (PADDR == omw_pkg::ADDR_WDG_CTRL) begin
					wdg_ctrl_reg <= PWDATA[7:0];
				end else if (PADDR == omw_pkg::ADDR_WAKE_EN) begin
					port_a_wake_enable_reg <= PWDATA[PORT_W-1:0]; // see RULE16
				end else if (PADDR == omw_pkg::ADDR_OSC_CFG) begin
					wdg_from_sub_reg <= PWDATA[0];
					hs_is_crystal_reg <= PWDATA[1];
				end
			end
		end
	end

	// mapped offsets; anything else answers with an error and changes nothing
	always_comb begin
		if (PADDR == omw_pkg::ADDR_SYS_MODE)
			addr_hit = 1'b1;
		else if (PADDR == omw_pkg::ADDR_WDG_CTRL)
			addr_hit = 1'b1;
		else if (PADDR == omw_pkg::ADDR_STATUS)
			addr_hit = 1'b1;
		else if (PADDR == omw_pkg::ADDR_WAKE_EN)
			addr_hit = 1'b1;
		else if (PADDR == omw_pkg::ADDR_OSC_CFG)
			addr_hit = 1'b1;
		else
			addr_hit = 1'b0;
	end

	// apb read data and response, no wait states on reads or writes
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			PRDATA <= '0;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			INT_PENDING <= '0;
		end else begin
			INT_PENDING <= int_pend_reg;
			PREADY <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && !addr_hit;
			if (rd_en) begin
				if (PADDR == omw_pkg::ADDR_SYS_MODE)
					PRDATA <= {24'h000000, smode_reg};
				else if (PADDR == omw_pkg::ADDR_WDG_CTRL)
					PRDATA <= {24'h000000, wdg_ctrl_reg};
				else if (PADDR == omw_pkg::ADDR_STATUS)
					PRDATA <= {24'h000000, 3'h0, st_reg[4:1], 1'b0} |
						{30'h00000000, power_down_flag_reg, timeout_flag_reg};
				else if (PADDR == omw_pkg::ADDR_WAKE_EN)
					PRDATA <= 32'(port_a_wake_enable_reg);
				else if (PADDR == omw_pkg::ADDR_OSC_CFG)
					PRDATA <= {30'h00000000, hs_is_crystal_reg, wdg_from_sub_reg};
				else
					PRDATA <= '0;
			end
		end
	end
endmodule

// >>> omw_core_model.sv
// partner model: core event pulses, interrupt request flags, port a pins
// assumes the controller samples everything on the rising clock edge
`timescale 1ns/1ps
module omw_core_model (
	// core side
	input wire logic clk,
	input wire logic halted,
	output logic [3:0] ev,
	output logic [7:0] int_req,
	// port a pins
	output logic [7:0] pins
);
	// pins rest high as if pulled up, so only a driven low makes a fall
	initial begin
		ev = 4'h0;
		int_req = 8'h00;
		pins = 8'hff;
	end
	// ev bits: ext reset, overflow, watchdog clear, halt; a halted core issues no halt
	task pulse(input int k);
		while (k == 0 && halted !== 1'b0) @(posedge clk);
		@(posedge clk);
		ev[k] <= 1'b1;
		@(posedge clk);
		ev[k] <= 1'b0;
	endtask
	task raise(input int b);
		@(posedge clk);
		int_req[b] <= 1'b1;
	endtask
	task clear_int;
		@(posedge clk);
		int_req <= 8'h00;
	endtask
	// held low long enough for the pin filter to agree
	task fall(input int b);
		@(posedge clk);
		pins[b] <= 1'b0;
		repeat (6) @(posedge clk);
		pins[b] <= 1'b1;
	endtask
endmodule

// >>> omw_ctrl_asserts.sv
// checker for the mode and wake-up controller, bound to its top module
// assumes the single ref clock and the synchronous active-low reset
`timescale 1ns/1ps
module omw_ctrl_asserts (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic HALT_EXEC,
	input wire logic WDG_OVERFLOW,
	input wire logic EXT_RESET_WAKE,
	input wire logic [7:0] INT_REQ,
	input wire logic [7:0] INT_ENABLE,
	input wire logic STACK_FULL,
	input wire omw_pkg::omw_clk_t CLK_CTRL,
	input wire logic WDG_RESET,
	input wire logic WDG_RUN,
	input wire logic CORE_HALTED,
	input wire logic WAKE_RESUME,
	input wire logic WAKE_PC_SP_RESET,
	input wire logic WAKE_FULL_RESET,
	input wire logic INT_SERVICE
);
	logic [2:0] age_reg;
	logic settled;
	// outputs are only trusted a few edges after reset lets go
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) age_reg <= 3'h0;
		else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
	end
	assign settled = (age_reg == 3'h7);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);
	property p_apb_ready; PSEL && !PENABLE |=> PREADY; endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("no ready after setup");
	property p_err_ready; PSLVERR |-> PREADY; endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	property p_halt_enter; settled && HALT_EXEC && !CORE_HALTED |-> ##[1:2] CORE_HALTED; endproperty
	a_halt_enter: assert property (p_halt_enter) else $error("halt not taken");
	property p_halt_wdg; settled && HALT_EXEC && !CORE_HALTED |-> ##[1:2] WDG_RESET; endproperty
	a_halt_wdg: assert property (p_halt_wdg) else $error("halt kept watchdog");
	property p_sys_stop; settled && !CLK_CTRL.sys_clk_on |-> CORE_HALTED || $past(CORE_HALTED); endproperty
	a_sys_stop: assert property (p_sys_stop) else $error("core runs unclocked");
	property p_deep_wdg; settled && CORE_HALTED && !CLK_CTRL.sub_clk_on |-> !WDG_RUN; endproperty
	a_deep_wdg: assert property (p_deep_wdg) else $error("watchdog runs in deep stop");
	property p_ext_wake;
		settled && EXT_RESET_WAKE && CORE_HALTED |-> ##[1:2] WAKE_FULL_RESET;
	endproperty
	a_ext_wake: assert property (p_ext_wake) else $error("no full reset wake");
	property p_ovf_wake;
		settled && WDG_OVERFLOW && !EXT_RESET_WAKE && CORE_HALTED |-> ##[1:2] WAKE_PC_SP_RESET;
	endproperty
	a_ovf_wake: assert property (p_ovf_wake) else $error("no overflow wake");
	property p_int_serv;
		INT_SERVICE |-> !$past(STACK_FULL) && |($past(INT_REQ) & $past(INT_ENABLE));
	endproperty
	a_int_serv: assert property (p_int_serv) else $error("bad interrupt service");
	property p_wake_one;
		$onehot0({WAKE_FULL_RESET, WAKE_PC_SP_RESET, WAKE_RESUME, INT_SERVICE});
	endproperty
	a_wake_one: assert property (p_wake_one) else $error("two wake kinds at once");
	c_halt: cover property (HALT_EXEC && !CORE_HALTED);
	c_ext: cover property (WAKE_FULL_RESET);
	c_serv: cover property (INT_SERVICE);
endmodule
bind omw_ctrl omw_ctrl_asserts chk_u (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .PSEL(PSEL),
	.PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .HALT_EXEC(HALT_EXEC),
	.WDG_OVERFLOW(WDG_OVERFLOW), .EXT_RESET_WAKE(EXT_RESET_WAKE), .INT_REQ(INT_REQ),
	.INT_ENABLE(INT_ENABLE), .STACK_FULL(STACK_FULL), .CLK_CTRL(CLK_CTRL),
	.WDG_RESET(WDG_RESET), .WDG_RUN(WDG_RUN), .CORE_HALTED(CORE_HALTED),
	.WAKE_RESUME(WAKE_RESUME), .WAKE_PC_SP_RESET(WAKE_PC_SP_RESET),
	.WAKE_FULL_RESET(WAKE_FULL_RESET), .INT_SERVICE(INT_SERVICE));

// >>> omw_ctrl_tb.sv
// testbench: apb master, four halt modes and their wake sources
// assumes shortened start-up counts so each wake settles in tens of cycles
`timescale 1ns/1ps
module omw_ctrl_tb;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic det_on = 1'b0, stack_full = 1'b0;
	logic [7:0] paddr = 8'h00, int_en = 8'hff, rnd = 8'h28, int_req, pins, int_pend;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] ev, ck[6] = '{4'h0, 4'h3, 4'h6, 4'hf, 4'h2, 4'hf};
	logic [7:0] stx[6] = '{8'h02, 8'h06, 8'h0a, 8'h12, 8'h06, 8'h12};
	logic pready, pslverr, wdg_reset, wdg_run, halted, w_res, w_pcsp, w_full, int_serv;
	omw_pkg::omw_clk_t clk_ctrl;
	int bad_count = 0, cmp_count = 0, m;
	logic [16:0] q_rd[$];
	logic [3:0] q_wk[$];
	omw_ctrl #(.HX_CYC(8), .RC_CYC(4), .LX_CYC(8)) dut_u (.REF_CLK(clk), .RESET_N(rst_n),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .HALT_EXEC(ev[0]),
		.WDG_CLEAR(ev[1]), .WDG_OVERFLOW(ev[2]), .DETECTOR_ON(det_on), .EXT_RESET_WAKE(ev[3]),
		.INT_REQ(int_req), .INT_ENABLE(int_en), .STACK_FULL(stack_full), .PORT_A_PIN(pins),
		.CLK_CTRL(clk_ctrl), .WDG_RESET(wdg_reset), .WDG_RUN(wdg_run), .CORE_HALTED(halted),
		.WAKE_RESUME(w_res), .WAKE_PC_SP_RESET(w_pcsp), .WAKE_FULL_RESET(w_full),
		.INT_SERVICE(int_serv), .INT_PENDING(int_pend));
	omw_core_model core_u (.clk(clk), .halted(halted), .ev(ev), .int_req(int_req), .pins(pins));
	initial forever #2 clk = ~clk;
	function logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task summarize;
		if (bad_count == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) bad_count++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] mk, input logic er);
		q_rd.push_back({er, mk, e});
		apb(1'b0, a, 32'h0);
	endtask
	task wait_run;
		int k;
		k = 0;
		while (halted !== 1'b0 && k < 400) begin
			@(posedge clk);
			k++;
		end
		chk(halted, 1'b0);
	endtask
	// results are matched in order of appearance against the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && q_rd.size() > 0) begin
			chk({pslverr, prdata[7:0] & q_rd[0][15:8]}, {q_rd[0][16], q_rd[0][7:0]});
			void'(q_rd.pop_front());
		end
		if (rst_n && {w_full, w_pcsp, w_res, int_serv} !== 4'h0)
			chk({w_full, w_pcsp, w_res, int_serv}, q_wk.size() > 0 ? q_wk.pop_front() : 4'hf);
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		summarize;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		wait_run;
		rd(8'h00, 8'h05, 8'hf7, 1'b0);
		rd(8'h04, 8'h7a, 8'hff, 1'b0);
		rd(8'h08, 8'h00, 8'hff, 1'b0);
		rd(8'h14, 8'h00, 8'hff, 1'b1);
		rnd = lfsr(rnd);
		apb(1'b1, 8'h0c, {24'h0, rnd});
		rd(8'h0c, rnd, 8'hff, 1'b0);
		apb(1'b1, 8'h00, 32'h0);
		repeat (40) @(posedge clk);
		chk({clk_ctrl.sys_from_low, clk_ctrl.high_osc_on}, 2'b10);
		rd(8'h00, 8'h08, 8'h08, 1'b0);
		rnd = lfsr(rnd);
		apb(1'b1, 8'h00, {24'h0, 3'(rnd % 8'h06) + 3'h2, 5'h00});
		repeat (40) @(posedge clk);
		chk({clk_ctrl.sys_from_low, clk_ctrl.high_osc_on}, 2'b01);
		rd(8'h00, 8'h04, 8'h04, 1'b0);
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h0c, 32'h1);
		for (m = 0; m < 6; m++) begin
			det_on <= (m == 4);
			stack_full <= (m == 5);
			int_en <= (m == 4) ? 8'hf7 : 8'hff;
			apb(1'b1, 8'h00, {27'h0, m == 1, 2'h0, m == 2 || m == 3 || m == 5, 1'b1});
			apb(1'b1, 8'h04, {24'h0, m == 3 || m == 5, 3'h7,
				(m == 0 || m == 4) ? 4'ha : 4'h5});
			if (m == 2) begin
				apb(1'b1, 8'h10, 32'h2);
				rd(8'h10, 8'h02, 8'hff, 1'b0);
			end
			if (m == 3) core_u.raise(1);
			core_u.pulse(0);
			repeat (4) @(posedge clk);
			chk({clk_ctrl.sys_clk_on, clk_ctrl.tbase_clk_on, clk_ctrl.sub_clk_on, wdg_run}, ck[m]);
			rd(8'h08, stx[m], 8'hff, 1'b0);
			case (m)
				0: begin
					q_wk.push_back(4'h2);
					core_u.fall(0);
				end
				1: begin
					q_wk.push_back(4'h4);
					core_u.pulse(2);
				end
				2: begin
					q_wk.push_back(4'h8);
					core_u.pulse(3);
				end
				4, 5: begin
					q_wk.push_back(4'h2);
					core_u.raise(m - 1);
				end
				default: begin
					repeat (8) @(posedge clk);
					chk(halted, 1'b1);
					q_wk.push_back(4'h1);
					core_u.raise(2);
				end
			endcase
			wait_run;
			if (m == 1) chk(clk_ctrl.sys_from_low, 1'b1);
			chk(int_pend, (m == 4) ? 8'h08 : (m == 5) ? 8'h10 : 8'h00);
			core_u.clear_int;
			if (m == 1) begin
				rd(8'h08, 8'h03, 8'h03, 1'b0);
				core_u.pulse(1);
				rd(8'h08, 8'h00, 8'h02, 1'b0);
				repeat (12) @(posedge clk);
				chk(clk_ctrl.sys_from_low, 1'b0);
			end
		end
		repeat (5) @(posedge clk);
		chk(q_wk.size(), 0);
		summarize;
	end
endmodule
